//--- rtl/next_address_map.svh
// constants for the microprogram next-address sequencer
`ifndef NEXT_ADDRESS_MAP_SVH
`define NEXT_ADDRESS_MAP_SVH
`define ADDR_W            8
`define FORCED_ADDR       8'h80
`define DECODE_FORK_BASE  8'hFF
`define SEL_NONE          4'h0
`define SEL_FIVE          4'h5
`define SEL_FOURTEEN      4'hC
`define SEL_FIFTEEN       4'hD
`define BRANCH_BIT_HI     5
`define BRANCH_BIT_LO     4
`define NO_BRANCH_BIT     3
`endif

//--- rtl/next_address_pkg.sv
// types for the microprogram next-address sequencer
package next_address_pkg;
   typedef logic [7:0] uaddr_t;
   typedef logic [3:0] branch_sel_t;
   typedef enum logic [2:0] {
      FORK_DECODE  = 3'b001,
      FORK_DEST    = 3'b010,
      FORK_EXECUTE = 3'b100
   } fork_onehot_t;
endpackage

//--- rtl/address_copy_reg.sv
// one copy of the control-store address register
`timescale 1ns/10ps
`include "next_address_map.svh"
module address_copy_reg
   import next_address_pkg::*;
(
   // clock and reset
   input  wire logic   clk_in,
   input  wire logic   nrst_in,
   // load
   input  wire logic   load_in,
   input  wire uaddr_t d_in,
   // stored address
   output uaddr_t      q_out
);
   // msb is its own flop so reset can set it, leaving the register at the forced vector 0x80
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q_out[7] <= 1'b1;
      end else if (load_in) begin
         q_out[7] <= d_in[7];
      end
   end
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q_out[6:0] <= 7'h00;
      end else if (load_in) begin
         q_out[6:0] <= d_in[6:0];
      end
   end
endmodule

//--- rtl/microprogram_next_address.sv
// next-address sequencer for the microprogram control store
//
// Functional notes
// [R1] address register loads on t3; it selects the next cycle's microword
// [R2] no fork and no branch: next address is the next-address field
// [R3] three identical address copies: two for control store, one for mmu
// [R4] forced entry loads 0x80: low seven bits clear, msb set
// [R5] forced entry on init, parity abort after pause, other abort in pause
// [R6] aborts qualified by timing state two so forced vector always wins
// [R7] each address bit ANDs three fork terms and a field-or-branch term
// [R8] forks disabled: bit set when field bit or branch signal asserted
// [R9] bit 3 has no branch input; its term is the field bit only
// [R10] at most one fork enabled; its term true when a decode output asserts
// [R11] branches only set bits, forks only clear; decode base is 0xFF
// [R12] decode fork acts whenever its enable is set
// [R13] dest fork off under select fourteen with source mode 3, 5 or 7
// [R14] execute fork under select fifteen only for the fj class
// [R15] execute fork off under select five for an odd-byte destination
// [R16] next-address field is a base that forks or branches may alter
// [R17] branches alter only bits 5 and 4, giving four alternatives
// [R18] four-bit select field picks one of 16 branch-condition sets
// [R19] selections zero and fourteen leave bits 5 and 4 unmodified
// [R20] forced entry overrides every other next-address source
`timescale 1ns/10ps
`include "next_address_map.svh"
module microprogram_next_address
   import next_address_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   // timing
   input  wire logic        t3_pulse_in,
   input  wire logic        timing_state_two_in,
   // microword fields
   input  wire uaddr_t      next_address_field_in,
   input  wire logic [2:0]  fork_enable_bits_in,
   input  wire branch_sel_t branch_select_field_in,
   // branch conditions, two per selection, bit 1 drives address bit 5
   input  wire logic [31:0] branch_cond_in,
   // fork decode outputs
   input  wire uaddr_t      decode_fork_in,
   input  wire uaddr_t      dest_fetch_fork_in,
   input  wire uaddr_t      execute_fork_in,
   // instruction qualifiers
   input  wire logic        source_mode_odd_high_in,
   input  wire logic        fj_class_in,
   input  wire logic        odd_byte_destination_in,
   // abort and init
   input  wire logic        rom_init_in,
   input  wire logic        parity_error_abort_in,
   input  wire logic        abort_in,
   input  wire logic        pause_cycle_in,
   input  wire logic        after_pause_in,
   // address copies
   output uaddr_t           store_addr_a_out,
   output uaddr_t           store_addr_b_out,
   output uaddr_t           mmu_addr_out,
   output logic             forced_entry_out
);
   // ---------------------------------------------------------------
   // branch selection
   // ---------------------------------------------------------------
   logic [1:0] branch_bit_signal;
   logic       decode_fork_enable;
   logic       dest_fetch_fork_enable;
   logic       execute_fork_enable;
   logic       forced_entry_request;
   uaddr_t     next_address_bits;
   uaddr_t     control_store_address_nxt;

   always_comb begin
      // see [R18]
      branch_bit_signal = {branch_cond_in[{branch_select_field_in, 1'b1}],
                           branch_cond_in[{branch_select_field_in, 1'b0}]};
      // see [R19]
      if (branch_select_field_in == `SEL_NONE ||
          branch_select_field_in == `SEL_FOURTEEN) begin
         branch_bit_signal = 2'b00;
      end
   end

   // ---------------------------------------------------------------
   // fork qualification
   // ---------------------------------------------------------------
   // enables from the microword are one-hot by microcode convention
   always_comb begin
      decode_fork_enable = fork_enable_bits_in[0]; // see [R12]
      // see [R13]
      dest_fetch_fork_enable = fork_enable_bits_in[1] &&
         !(branch_select_field_in == `SEL_FOURTEEN &&
           source_mode_odd_high_in);
      execute_fork_enable = fork_enable_bits_in[2];
      // see [R14]
      if (branch_select_field_in == `SEL_FIFTEEN && !fj_class_in) begin
         execute_fork_enable = 1'b0;
      end
      // see [R15]
      if (branch_select_field_in == `SEL_FIVE && odd_byte_destination_in)
      begin
         execute_fork_enable = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // address bit gating
   // ---------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `ADDR_W; gi++) begin : g_bit
         logic base_term;
         // see [R9] see [R17]
         if (gi == `BRANCH_BIT_HI || gi == `BRANCH_BIT_LO) begin : g_br
            // see [R8] see [R11]
            assign base_term = next_address_field_in[gi] |
                               branch_bit_signal[gi - `BRANCH_BIT_LO];
         end else begin : g_nobr
            assign base_term = next_address_field_in[gi];
         end
         // see [R7] see [R10] see [R2] see [R16]
         assign next_address_bits[gi] = base_term &
            (!decode_fork_enable     || decode_fork_in[gi]) &
            (!dest_fetch_fork_enable || dest_fetch_fork_in[gi]) &
            (!execute_fork_enable    || execute_fork_in[gi]);
      end
   endgenerate

   // ---------------------------------------------------------------
   // forced entry
   // ---------------------------------------------------------------
   // abort terms held by timing state two, which outlasts the t3 pulse
   always_comb begin
      // see [R5] see [R6]
      forced_entry_request = rom_init_in ||
         (timing_state_two_in &&
          ((parity_error_abort_in && after_pause_in) ||
           (abort_in && pause_cycle_in)));
      // see [R20] see [R4]
      control_store_address_nxt = forced_entry_request ?
                                  `FORCED_ADDR : next_address_bits;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         forced_entry_out <= 1'b0;
      end else if (t3_pulse_in) begin
         forced_entry_out <= forced_entry_request;
      end
   end

   // ---------------------------------------------------------------
   // address register copies
   // ---------------------------------------------------------------
   // separate copies keep fanout low on the control-store path
   address_copy_reg u_copy_a (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .load_in (t3_pulse_in),               // see [R1]
      .d_in    (control_store_address_nxt),
      .q_out   (store_addr_a_out)           // see [R3]
   );
   address_copy_reg u_copy_b (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .load_in (t3_pulse_in),
      .d_in    (control_store_address_nxt),
      .q_out   (store_addr_b_out)
   );
   address_copy_reg u_copy_mmu (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .load_in (t3_pulse_in),
      .d_in    (control_store_address_nxt),
      .q_out   (mmu_addr_out)
   );
endmodule

//--- tb/next_address_props.sv
// assertions for the next-address sequencer
`timescale 1ns/10ps
module next_address_props
   import next_address_pkg::*;
(
   input wire logic clk_in, nrst_in, t3_pulse_in, timing_state_two_in,
   input wire logic rom_init_in, parity_error_abort_in, abort_in,
   input wire logic pause_cycle_in, after_pause_in, forced_entry_out,
   input wire uaddr_t next_address_field_in, decode_fork_in,
   input wire uaddr_t store_addr_a_out, store_addr_b_out, mmu_addr_out,
   input wire logic [2:0] fork_enable_bits_in,
   input wire branch_sel_t branch_select_field_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   wire logic ab = parity_error_abort_in & after_pause_in
                 | abort_in & pause_cycle_in;
   wire logic frc = rom_init_in | timing_state_two_in & ab;
   wire logic go = t3_pulse_in & !frc;
   wire logic nf = fork_enable_bits_in == 3'h0;
   wire uaddr_t f = next_address_field_in;
   wire uaddr_t q = store_addr_a_out;
   a_load_hold:
      assert property (!t3_pulse_in |=> $stable(q)) else $error("moved");
   a_copies_same:
      assert property (q == store_addr_b_out && q == mmu_addr_out)
      else $error("copies differ");
   a_init_vector:
      assert property (t3_pulse_in & rom_init_in |=>
         q == 8'h80 && forced_entry_out) else $error("no init vector");
   a_abort_force:
      assert property (t3_pulse_in & timing_state_two_in & ab |=>
         q == 8'h80) else $error("no abort vector");
   a_abort_gate:
      assert property (t3_pulse_in & !rom_init_in & !timing_state_two_in
         |=> !forced_entry_out) else $error("ungated abort");
   a_plain_field:
      assert property (go & nf & branch_select_field_in == 4'h0 |=>
         q == $past(f)) else $error("not field");
   a_bit3_field:
      assert property (go & nf |=> q[3] == $past(f[3])) else $error("bit3");
   a_branch_bits:
      assert property (go & nf |=> ((q ^ $past(f)) & 8'hCF) == 8'h00
         && (~q & $past(f)) == 8'h00) else $error("branch bits");
   // branches may still set bits 5 and 4, so those are only checked cleared
   a_decode_fork:
      assert property (go & fork_enable_bits_in == 3'h1 |=>
         ((q ^ ($past(f) & $past(decode_fork_in))) & 8'hCF) == 8'h00
         && (q & ~$past(decode_fork_in)) == 8'h00) else $error("decode");
endmodule
bind microprogram_next_address next_address_props chk (.*);

//--- tb/fork_logic_model.sv
// fork decode logic standing beside the sequencer
`timescale 1ns/10ps
module fork_logic_model
   import next_address_pkg::*;
(
   input  wire uaddr_t ir_in,
   output uaddr_t      decode_fork_out,
   output uaddr_t      dest_fetch_fork_out,
   output uaddr_t      execute_fork_out
);
   // distinct patterns, so a wrong fork choice shows
   assign decode_fork_out     = ir_in;
   assign dest_fetch_fork_out = ir_in ^ 8'h0F;
   assign execute_fork_out    = ir_in ^ 8'hF0;
endmodule

//--- tb/tb_microprogram_next_address.sv
// self-checking bench for the next-address sequencer
`timescale 1ns/10ps
module tb_microprogram_next_address
   import next_address_pkg::*;
;
   logic        clk_in = 1'b0, nrst_in = 1'b0, t3 = 1'b0, fe;
   uaddr_t      fld = 8'h00, ir = 8'h3C, dfk, cfk, bfk, a, b, m;
   logic [2:0]  fk = 3'h0;
   branch_sel_t s = 4'h0;
   logic [9:0]  x = 10'h000;
   int          error_cnt = 0, compares = 0, cyc = 0;
   microprogram_next_address dut (.clk_in(clk_in), .nrst_in(nrst_in),
      .t3_pulse_in(t3), .timing_state_two_in(x[5]),
      .next_address_field_in(fld), .fork_enable_bits_in(fk),
      .branch_select_field_in(s), .branch_cond_in({32{x[9]}}),
      .decode_fork_in(dfk), .dest_fetch_fork_in(cfk),
      .execute_fork_in(bfk), .source_mode_odd_high_in(x[6]),
      .fj_class_in(x[7]), .odd_byte_destination_in(x[8]),
      .rom_init_in(x[0]), .parity_error_abort_in(x[1]),
      .abort_in(x[2]), .pause_cycle_in(x[3]), .after_pause_in(x[4]),
      .store_addr_a_out(a), .store_addr_b_out(b), .mmu_addr_out(m),
      .forced_entry_out(fe));
   fork_logic_model fl (.ir_in(ir), .decode_fork_out(dfk),
      .dest_fetch_fork_out(cfk), .execute_fork_out(bfk));
   initial forever #4 clk_in = ~clk_in;
   task automatic results();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // well past the ~60 cycles the sequence needs
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 500) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input uaddr_t g, input uaddr_t e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // x: cond, odd, fj, smode, ts2, after, pause, abort, pe, init
   task automatic ld(input uaddr_t f, input logic [2:0] k,
      input branch_sel_t q, input logic [9:0] y, input uaddr_t e);
      @(posedge clk_in);
      fld <= f;
      fk <= k;
      s <= q;
      x <= y;
      t3 <= 1'b1;
      @(posedge clk_in);
      t3 <= 1'b0;
      #1;
      chk(a, e);
      chk(b, e);
      chk(m, e);
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      #1 chk(a, 8'h80);
      chk({7'h00, fe}, 8'h00);
      ld(8'h5A, 3'h0, 4'h0, 10'h200, 8'h5A);
      ld(8'h00, 3'h0, 4'h1, 10'h200, 8'h30);
      for (int i = 0; i < 16; i++)
         ld(8'h08, 3'h0, i[3:0], 10'h200,
            (i == 0 || i == 12) ? 8'h08 : 8'h38);
      ld(8'hFF, 3'h1, 4'h0, 10'h000, 8'h3C);
      ld(8'hFF, 3'h2, 4'hC, 10'h040, 8'hFF);
      ld(8'hFF, 3'h2, 4'hC, 10'h000, 8'h33);
      ld(8'hFF, 3'h4, 4'hD, 10'h000, 8'hFF);
      ld(8'hFF, 3'h4, 4'hD, 10'h080, 8'hCC);
      ld(8'hFF, 3'h4, 4'h5, 10'h100, 8'hFF);
      ld(8'hFF, 3'h4, 4'h5, 10'h000, 8'hCC);
      ld(8'h12, 3'h1, 4'h1, 10'h201, 8'h80);
      chk({7'h00, fe}, 8'h01);
      ld(8'h12, 3'h0, 4'h0, 10'h00C, 8'h12);
      chk({7'h00, fe}, 8'h00);
      ld(8'h12, 3'h0, 4'h0, 10'h02C, 8'h80);
      chk({7'h00, fe}, 8'h01);
      ld(8'h12, 3'h0, 4'h0, 10'h032, 8'h80);
      ld(8'h12, 3'h0, 4'h0, 10'h034, 8'h12);
      @(posedge clk_in);
      fld <= 8'h77;
      repeat (2) @(posedge clk_in);
      #1 chk(a, 8'h12);
      results();
   end
endmodule
